// >>> hdl/prs_pkg.sv
package prs_pkg;

  // ********************************************************
  // resource map
  // ********************************************************
  localparam int NUM_RES = 8;
  localparam int NUM_CLK_REQ = 4;
  localparam int TIMER_W = 8;
  localparam int RES_CORE_SW = 0;
  localparam int RES_CORE_LIN = 1;
  localparam int RES_LOWNOISE_LIN = 2;
  localparam int RES_SHORTRANGE_SEC = 3;
  localparam int RES_WLAN_SEC = 4;
  localparam int RES_LOAD_HIGH = 5;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int REF_CLK_HZ = 50000000;
  localparam int LPO_HZ = 32768;
  localparam int SYNC_STAGES = 3;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [7:0] MIN_MASK_RST = 8'h00;
  localparam logic [7:0] TIME_RST = 8'h00;
  localparam logic [7:0] DEP_RST = 8'h00;

  typedef logic [NUM_RES-1:0] prs_vec_t;

  typedef enum logic [1:0] {
    RS_DISABLED,
    RS_ENABLED,
    RS_RISING,
    RS_FALLING
  } prs_rstate_t;

  typedef enum logic [1:0] {
    PM_POWER_DOWN,
    PM_ACTIVE,
    PM_DOZE,
    PM_DEEP_SLEEP
  } prs_mode_t;

  typedef struct packed {
    logic [NUM_RES-1:0][TIMER_W-1:0] time_on;
    logic [NUM_RES-1:0][TIMER_W-1:0] time_off;
    logic [NUM_RES-1:0][NUM_RES-1:0] depends_on;
    logic [NUM_CLK_REQ-1:0][NUM_RES-1:0] clk_map;
    prs_vec_t min_mask;
    prs_vec_t timer_req;
  } prs_cfg_t;

  typedef struct packed {
    prs_vec_t pending;
    prs_vec_t state;
  } prs_stat_t;

endpackage

// >>> hdl/prs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module prs_sequencer
  import prs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pins and oscillator
  input wire logic low_power_oscillator,
  input wire logic shortrange_power_request,
  input wire logic wlan_power_request,
  // requests and configuration
  input wire logic [NUM_CLK_REQ-1:0] clk_req,
  input wire logic baseband_high_load,
  input wire logic doze_req,
  input wire logic deep_sleep_req,
  input wire logic wake_event,
  input wire logic retention_done,
  input wire prs_cfg_t cfg,
  // status and controls
  output prs_stat_t status_q,
  output prs_mode_t mode_q,
  output logic core_switching_regulator_q,
  output logic core_linear_regulator_q,
  output logic low_noise_linear_regulator_q,
  output logic shortrange_reset_n_q,
  output logic wlan_reset_n_q,
  output logic main_clk_en_q,
  output logic clk_slow_q,
  output logic retention_save_q,
  output logic retention_restore_q
);

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic [SYNC_STAGES-1:0] lpo_s_q, sr_s_q, wl_s_q;
  logic sr_q, wl_q, lpo_q;
  always_ff @(posedge ref_clk) begin
    lpo_s_q <= {lpo_s_q[1:0], low_power_oscillator};
    sr_s_q <= {sr_s_q[1:0], shortrange_power_request};
    wl_s_q <= {wl_s_q[1:0], wlan_power_request};
  end
  // change accepted once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sr_q <= 1'b0;
      wl_q <= 1'b0;
      lpo_q <= 1'b0;
    end else begin
      if (sr_s_q[1] == sr_s_q[2]) sr_q <= sr_s_q[2];
      if (wl_s_q[1] == wl_s_q[2]) wl_q <= wl_s_q[2];
      if (lpo_s_q[1] == lpo_s_q[2]) lpo_q <= lpo_s_q[2];
    end
  end
  wire logic lpo_prev_d;
  logic lpo_prev_q;
  assign lpo_prev_d = lpo_q;
  always_ff @(posedge ref_clk) lpo_prev_q <= rst ? 1'b0 : lpo_prev_d;
  // one sequencer step per oscillator rising edge
  wire logic tick = lpo_q & ~lpo_prev_q;
  wire logic any_req = sr_q | wl_q;

  // ********************************************************
  // required set
  // ********************************************************
  function automatic prs_vec_t map_clocks(input logic [NUM_CLK_REQ-1:0] r,
                                          input prs_cfg_t c);
    prs_vec_t m;
    m = '0;
    for (int i = 0; i < NUM_CLK_REQ; i++) if (r[i]) m = m | c.clk_map[i];
    return m;
  endfunction

  prs_vec_t ext_req;
  always_comb begin
    ext_req = '0;
    ext_req[RES_CORE_SW] = any_req;
    ext_req[RES_CORE_LIN] = any_req & baseband_high_load;
    ext_req[RES_LOWNOISE_LIN] = any_req & baseband_high_load;
    ext_req[RES_SHORTRANGE_SEC] = sr_q;
    ext_req[RES_WLAN_SEC] = wl_q;
  end
  // union of all sources, regulators only while powered
  wire prs_vec_t required = ext_req | ({NUM_RES{any_req}} &
      (map_clocks(clk_req, cfg) | cfg.min_mask | cfg.timer_req));

  // ********************************************************
  // per-resource state and timers
  // ********************************************************
  prs_rstate_t rs_q [NUM_RES];
  logic [TIMER_W-1:0] tmr_q [NUM_RES];
  prs_vec_t enabled_v, live_v, dependents_up, deps_ok;
  always_comb begin
    for (int i = 0; i < NUM_RES; i++) begin
      enabled_v[i] = (rs_q[i] == RS_ENABLED);
      live_v[i] = (rs_q[i] != RS_DISABLED);
    end
    for (int i = 0; i < NUM_RES; i++) begin
      dependents_up[i] = 1'b0;
      deps_ok[i] = ((cfg.depends_on[i] & ~enabled_v) == '0);
      for (int j = 0; j < NUM_RES; j++)
        if (cfg.depends_on[j][i] && live_v[j]) dependents_up[i] = 1'b1;
    end
  end
  wire prs_vec_t start_on = ~live_v & required & deps_ok;
  wire prs_vec_t start_off = enabled_v & ~required & ~dependents_up;

  for (genvar g = 0; g < NUM_RES; g++) begin : g_res
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        rs_q[g] <= RS_DISABLED;
        tmr_q[g] <= TIME_RST;
      end else if (tick) begin
        case (rs_q[g])
          RS_DISABLED: if (start_on[g]) begin
            if (cfg.time_on[g] == '0) rs_q[g] <= RS_ENABLED;
            else begin
              rs_q[g] <= RS_RISING;
              tmr_q[g] <= cfg.time_on[g];
            end
          end
          RS_ENABLED: if (start_off[g]) begin
            if (cfg.time_off[g] == '0) rs_q[g] <= RS_DISABLED;
            else begin
              rs_q[g] <= RS_FALLING;
              tmr_q[g] <= cfg.time_off[g];
            end
          end
          RS_RISING, RS_FALLING: begin
            tmr_q[g] <= tmr_q[g] - 8'h01;
            if (tmr_q[g] == 8'h01)
              rs_q[g] <= (rs_q[g] == RS_RISING) ? RS_ENABLED : RS_DISABLED;
          end
          default: rs_q[g] <= RS_DISABLED;
        endcase
      end
    end
  end

  // ********************************************************
  // power mode
  // ********************************************************
  prs_mode_t mode_d;
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PM_POWER_DOWN: if (any_req) mode_d = PM_ACTIVE;
      PM_ACTIVE: begin
        // never sleep on a stale done flag: the save strobe must already stand
        if (deep_sleep_req && retention_done && retention_save_q) mode_d = PM_DEEP_SLEEP;
        else if (doze_req) mode_d = PM_DOZE;
      end
      PM_DOZE, PM_DEEP_SLEEP: if (wake_event || tick && cfg.timer_req != '0)
        mode_d = PM_ACTIVE;
      default: mode_d = PM_POWER_DOWN;
    endcase
    if (!any_req) mode_d = PM_POWER_DOWN;
  end

  // ********************************************************
  // outputs
  // ********************************************************
  prs_stat_t stat_d;
  always_comb begin
    for (int i = 0; i < NUM_RES; i++) begin
      stat_d.pending[i] = (rs_q[i] == RS_RISING) || (rs_q[i] == RS_FALLING);
      stat_d.state[i] = (rs_q[i] == RS_ENABLED) || (rs_q[i] == RS_FALLING);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= PM_POWER_DOWN;
      status_q <= '0;
      core_switching_regulator_q <= 1'b0;
      core_linear_regulator_q <= 1'b0;
      low_noise_linear_regulator_q <= 1'b0;
      shortrange_reset_n_q <= 1'b0;
      wlan_reset_n_q <= 1'b0;
      main_clk_en_q <= 1'b0;
      clk_slow_q <= 1'b0;
      retention_save_q <= 1'b0;
      retention_restore_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      status_q <= stat_d;
      core_switching_regulator_q <= live_v[RES_CORE_SW];
      core_linear_regulator_q <= live_v[RES_CORE_LIN];
      low_noise_linear_regulator_q <= live_v[RES_LOWNOISE_LIN];
      shortrange_reset_n_q <= sr_q & enabled_v[RES_SHORTRANGE_SEC];
      wlan_reset_n_q <= wl_q & enabled_v[RES_WLAN_SEC];
      main_clk_en_q <= (mode_d == PM_ACTIVE);
      // slow clock when nothing beyond the minimum is wanted
      clk_slow_q <= (mode_d == PM_ACTIVE) && (clk_req == '0) && !baseband_high_load;
      retention_save_q <= (mode_q == PM_ACTIVE) && deep_sleep_req;
      retention_restore_q <= (mode_q == PM_DEEP_SLEEP) && (mode_d == PM_ACTIVE);
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  property p_pd_regs_off;
    @(posedge ref_clk) disable iff (rst)
      $rose(core_switching_regulator_q) |-> $past(any_req);
  endproperty
  a_pd_regs_off: assert property (p_pd_regs_off)
    else $error("regulator up without request");
  // a live request must never let the switching regulator start to fall
  property p_req_holds;
    @(posedge ref_clk) disable iff (rst)
      tick && any_req && enabled_v[RES_CORE_SW] |=> enabled_v[RES_CORE_SW];
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("regulator dropped under request");
  property p_sect_reset;
    @(posedge ref_clk) disable iff (rst) !wl_q |=> !wlan_reset_n_q;
  endproperty
  a_sect_reset: assert property (p_sect_reset)
    else $error("section left reset unasked");
  property p_doze_clk;
    @(posedge ref_clk) disable iff (rst) mode_q != PM_ACTIVE |-> !main_clk_en_q;
  endproperty
  a_doze_clk: assert property (p_doze_clk)
    else $error("main clock on outside active");
  property p_save_first;
    @(posedge ref_clk) disable iff (rst)
      mode_q == PM_ACTIVE && mode_d == PM_DEEP_SLEEP |-> retention_save_q;
  endproperty
  a_save_first: assert property (p_save_first)
    else $error("deep sleep before state save");
  sequence s_wake_up;
    mode_q == PM_DEEP_SLEEP && mode_d == PM_ACTIVE;
  endsequence
  property p_restore;
    @(posedge ref_clk) disable iff (rst)
      s_wake_up |=> retention_restore_q && mode_q == PM_ACTIVE;
  endproperty
  a_restore: assert property (p_restore)
    else $error("wake without state restore");
  property p_pd_exit;
    @(posedge ref_clk) disable iff (rst)
      mode_q == PM_POWER_DOWN && !any_req |=> mode_q == PM_POWER_DOWN;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("left power-down unasked");

  // every resource checked, not only the ones a given test happens to time
  for (genvar k = 0; k < NUM_RES; k++) begin : g_chk
    sequence s_timed_on;
      tick && start_on[k] && cfg.time_on[k] != '0;
    endsequence
    sequence s_timed_off;
      tick && start_off[k] && cfg.time_off[k] != '0;
    endsequence
    property p_timer_zero;
      @(posedge ref_clk) disable iff (rst)
        (rs_q[k] == RS_ENABLED || rs_q[k] == RS_DISABLED) |-> tmr_q[k] == '0;
    endproperty
    a_timer_zero: assert property (p_timer_zero)
      else $error("settled timer nonzero");
    property p_timer_nz;
      @(posedge ref_clk) disable iff (rst)
        (rs_q[k] == RS_RISING || rs_q[k] == RS_FALLING) |-> tmr_q[k] != '0;
    endproperty
    a_timer_nz: assert property (p_timer_nz)
      else $error("transit timer zero");
    property p_zero_on;
      @(posedge ref_clk) disable iff (rst)
        tick && start_on[k] && cfg.time_on[k] == '0 |=> rs_q[k] == RS_ENABLED;
    endproperty
    a_zero_on: assert property (p_zero_on)
      else $error("zero delay not immediate");
    property p_zero_off;
      @(posedge ref_clk) disable iff (rst)
        tick && start_off[k] && cfg.time_off[k] == '0 |=> rs_q[k] == RS_DISABLED;
    endproperty
    a_zero_off: assert property (p_zero_off)
      else $error("zero delay off not immediate");
    property p_load_on;
      @(posedge ref_clk) disable iff (rst)
        s_timed_on |=> rs_q[k] == RS_RISING && tmr_q[k] == $past(cfg.time_on[k]);
    endproperty
    a_load_on: assert property (p_load_on)
      else $error("timer not loaded");
    property p_load_off;
      @(posedge ref_clk) disable iff (rst)
        s_timed_off |=> rs_q[k] == RS_FALLING && tmr_q[k] == $past(cfg.time_off[k]);
    endproperty
    a_load_off: assert property (p_load_off)
      else $error("off timer not loaded");
    property p_dec;
      @(posedge ref_clk) disable iff (rst)
        tick && (rs_q[k] == RS_RISING || rs_q[k] == RS_FALLING) |=> tmr_q[k] == $past(tmr_q[k]) - 8'h01;
    endproperty
    a_dec: assert property (p_dec)
      else $error("timer did not decrement");
    property p_off_guard;
      @(posedge ref_clk) disable iff (rst)
        tick && rs_q[k] == RS_ENABLED && dependents_up[k] |=> rs_q[k] == RS_ENABLED;
    endproperty
    a_off_guard: assert property (p_off_guard)
      else $error("disabled under dependent");
    property p_on_guard;
      @(posedge ref_clk) disable iff (rst)
        tick && rs_q[k] == RS_DISABLED && !deps_ok[k] |=> rs_q[k] == RS_DISABLED;
    endproperty
    a_on_guard: assert property (p_on_guard)
      else $error("enabled before dependency");
  end

endmodule
`default_nettype wire

// >>> verif/prs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module prs_host_model (
  // clock
  input wire logic ref_clk,
  // wishes from the bench, bit 0 short range, bit 1 wlan
  input wire logic [1:0] want,
  // section power-request pins
  output logic shortrange_power_request,
  output logic wlan_power_request
);
  // pins move just after an edge and then hold, like host firmware
  always @(posedge ref_clk) begin
    shortrange_power_request <= want[0];
    wlan_power_request <= want[1];
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import prs_pkg::*;
;
  // ************
  // stimulus
  // ************
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic low_power_oscillator = 1'b0;
  logic [4:0] osc_cnt = 5'h00;
  logic [1:0] want = 2'h0;
  logic [NUM_CLK_REQ-1:0] clk_req = '0;
  logic baseband_high_load = 1'b0;
  logic doze_req = 1'b0;
  logic wake_event = 1'b0;
  logic deep_sleep_req = 1'b0;
  logic retention_done = 1'b0;
  prs_cfg_t cfg = '0;
  logic shortrange_power_request, wlan_power_request;
  prs_stat_t status_q;
  prs_mode_t mode_q;
  logic core_switching_regulator_q, core_linear_regulator_q, low_noise_linear_regulator_q;
  logic shortrange_reset_n_q, wlan_reset_n_q, main_clk_en_q, clk_slow_q;
  logic retention_save_q, retention_restore_q;
  int n_errors = 0;
  int tests_run = 0;

  always #10 ref_clk = ~ref_clk;
  // fast oscillator stand-in keeps the run short; one tick per 20 cycles
  always @(posedge ref_clk) begin
    osc_cnt <= (osc_cnt == 5'h09) ? 5'h00 : osc_cnt + 5'h01;
    if (osc_cnt == 5'h09) begin
      low_power_oscillator <= ~low_power_oscillator;
    end
  end

  prs_host_model host (.ref_clk, .want, .shortrange_power_request, .wlan_power_request);
  prs_sequencer dut (.ref_clk, .rst, .low_power_oscillator, .shortrange_power_request,
    .wlan_power_request, .clk_req, .baseband_high_load, .doze_req,
    .deep_sleep_req, .wake_event, .retention_done, .cfg, .status_q, .mode_q,
    .core_switching_regulator_q, .core_linear_regulator_q, .low_noise_linear_regulator_q,
    .shortrange_reset_n_q, .wlan_reset_n_q, .main_clk_en_q, .clk_slow_q,
    .retention_save_q, .retention_restore_q);

  // ************
  // helpers
  // ************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // settle past the edge so sampling never races the design
  task automatic ticks(input int n);
    repeat (n * 20) @(posedge ref_clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ************
  // scenarios
  // ************
  task automatic t_idle();
    ticks(3);
    check(status_q, 16'h0000);
    check(mode_q, PM_POWER_DOWN);
    check(core_switching_regulator_q, 1'b0);
  endtask

  task automatic t_power_up();
    @(posedge ref_clk);
    want <= 2'h2;
    ticks(5);
    check(core_switching_regulator_q, 1'b1);
    check(wlan_reset_n_q, 1'b1);
    check(shortrange_reset_n_q, 1'b0);
    check(mode_q, PM_ACTIVE);
    check(clk_slow_q, 1'b1);
    @(posedge ref_clk);
    baseband_high_load <= 1'b1;
    ticks(3);
    check({core_linear_regulator_q, low_noise_linear_regulator_q}, 2'h3);
    @(posedge ref_clk);
    baseband_high_load <= 1'b0;
    ticks(3);
    check({core_linear_regulator_q, low_noise_linear_regulator_q}, 2'h0);
  endtask

  // resource 6 leans on resource 5, which takes three ticks to come up
  task automatic t_timed_chain();
    @(posedge ref_clk);
    cfg.min_mask <= 8'h60;
    ticks(2);
    check(status_q.pending[5], 1'b1);
    check(status_q.state[5], 1'b0);
    check(status_q.state[6], 1'b0);
    ticks(5);
    check(status_q.state[6:5], 2'h3);
    check(status_q.pending[6:5], 2'h0);
    @(posedge ref_clk);
    cfg.min_mask <= 8'h40;
    ticks(4);
    check(status_q.state[5], 1'b1);
    @(posedge ref_clk);
    cfg.min_mask <= 8'h00;
    ticks(2);
    check({status_q.pending[6], status_q.state[6]}, 2'h3);
    check(status_q.state[5], 1'b1);
    ticks(6);
    check(status_q, 16'h0011);
  endtask

  task automatic t_clock_and_doze();
    @(posedge ref_clk);
    clk_req <= 4'h1;
    ticks(3);
    check(status_q.state[7], 1'b1);
    check(clk_slow_q, 1'b0);
    @(posedge ref_clk);
    clk_req <= 4'h0;
    doze_req <= 1'b1;
    ticks(3);
    check({mode_q, main_clk_en_q}, {PM_DOZE, 1'b0});
    @(posedge ref_clk);
    doze_req <= 1'b0;
    wake_event <= 1'b1;
    ticks(3);
    check({mode_q, main_clk_en_q}, {PM_ACTIVE, 1'b1});
    @(posedge ref_clk);
    wake_event <= 1'b0;
  endtask

  // state saved before the core sleeps; a request timer wakes it
  task automatic t_deep_sleep();
    int n = 0;
    @(posedge ref_clk);
    deep_sleep_req <= 1'b1;
    @(posedge ref_clk);
    #1;
    check({mode_q, retention_save_q}, {PM_ACTIVE, 1'b1});
    @(posedge ref_clk);
    retention_done <= 1'b1;
    ticks(1);
    check({mode_q, main_clk_en_q, retention_save_q}, {PM_DEEP_SLEEP, 2'h0});
    @(posedge ref_clk);
    deep_sleep_req <= 1'b0;
    retention_done <= 1'b0;
    cfg.timer_req <= 8'h20;
    while (retention_restore_q !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (retention_restore_q !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end else begin
      check(mode_q, PM_ACTIVE);
      ticks(1);
      check({retention_restore_q, status_q.pending[5]}, 2'h1);
      @(posedge ref_clk);
      cfg.timer_req <= 8'h00;
    end
  endtask

  task automatic t_power_down();
    @(posedge ref_clk);
    want <= 2'h1;
    ticks(5);
    check({core_switching_regulator_q, shortrange_reset_n_q, wlan_reset_n_q}, 3'h6);
    @(posedge ref_clk);
    want <= 2'h0;
    ticks(5);
    check({core_switching_regulator_q, shortrange_reset_n_q, wlan_reset_n_q}, 3'h0);
    check(mode_q, PM_POWER_DOWN);
  endtask

  initial begin
    cfg.depends_on[RES_WLAN_SEC] = 8'h01;
    cfg.depends_on[RES_SHORTRANGE_SEC] = 8'h01;
    cfg.depends_on[6] = 8'h20;
    cfg.time_on[5] = 8'h03;
    cfg.time_off[6] = 8'h02;
    cfg.clk_map[0] = 8'h80;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_idle();
    t_power_up();
    t_timed_chain();
    t_clock_and_doze();
    t_deep_sleep();
    t_power_down();
    report_and_stop();
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
